// *** inc/ebc_pkg.sv ***
/*
  package for the external bus controller: mode codes, window configuration
  layout, timing field widths and reset values.
  assumes a single 10 MHz cpu clock domain.
*/
`default_nettype none
package ebc_pkg;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          HALF_CLK_NS    = 50;
  localparam int          NUM_WIN        = 4;
  // bus mode codes
  localparam logic [1:0]  MODE_DEMUX16   = 2'h0;
  localparam logic [1:0]  MODE_MUX16     = 2'h1;
  localparam logic [1:0]  MODE_MUX8      = 2'h2;
  localparam logic [1:0]  MODE_DEMUX8    = 2'h3;
  // address space codes and upper address line masks
  localparam logic [1:0]  SPACE_64K      = 2'h0;
  localparam logic [1:0]  SPACE_256K     = 2'h1;
  localparam logic [1:0]  SPACE_1M       = 2'h2;
  localparam logic [1:0]  SPACE_16M      = 2'h3;
  localparam logic [7:0]  SEG_MASK_64K   = 8'h00;
  localparam logic [7:0]  SEG_MASK_256K  = 8'h03;
  localparam logic [7:0]  SEG_MASK_1M    = 8'h0f;
  localparam logic [7:0]  SEG_MASK_16M   = 8'hff;
  localparam logic [3:0]  CYC_RESET      = 4'h0;

  // one bus configuration (default or window)
  typedef struct packed {
    logic       enable;      // window active in decode; ignored for the default
    logic [1:0] mode;
    logic [3:0] wait_cyc;    // memory cycle time, extra wait states
    logic       tristate;    // one extra tri-state cycle after read
    logic       ale_long;    // address latch strobe one extra cycle
    logic       rw_delay;    // read/write strobe delayed one cycle
    logic       rdy_en;
    logic       rdy_pol;     // ready_polarity_bit
  } bus_cfg_t;

  // window_select_reg: base page and size as mask of compared bits
  typedef struct packed {
    logic [11:0] base;
    logic [11:0] mask;
  } win_sel_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cpu_req_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ALE  = 7'b0000010,
    S_ADDR = 7'b0000100,
    S_WAIT = 7'b0001000,
    S_STRB = 7'b0010000,
    S_TRI  = 7'b0100000,
    S_HOLD = 7'b1000000
  } ebc_state_t;
endpackage
`default_nettype wire

// *** rtl/ext_bus_ctrl.sv ***
/*
  external bus controller: runs off-chip accesses in four bus modes with
  four windows plus a default region, chip selects, ready and hold arbitration.
  assumes pins are synchronised here; cpu request is held until done pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_bus_ctrl
  import ebc_pkg::*;
(
  input  wire logic                      MCLK_I,
  input  wire logic                      RST_I,
  input  wire cpu_req_t                  CPU_REQ_I,
  output logic                           CPU_DONE_O,
  output logic [15:0]                    CPU_RDATA_O,
  input  wire bus_cfg_t                  DEFAULT_CFG_I,
  input  wire bus_cfg_t [NUM_WIN-1:0]    WIN_CFG_I,
  input  wire win_sel_t [NUM_WIN-1:0]    WIN_SEL_I,
  input  wire logic                      SINGLE_CHIP_I,
  input  wire logic [1:0]                ADDR_SPACE_I,
  input  wire logic                      CS_TIMING_I,
  input  wire logic                      ARB_ENABLE_I,
  input  wire logic                      ACK_DIR_I,
  output logic [15:0]                    ADDRESS_PORT_O,
  output logic [15:0]                    DATA_PORT_O,
  output logic [15:0]                    DATA_PORT_OE_O,
  input  wire logic [15:0]               DATA_PORT_I,
  output logic [7:0]                     SEGMENT_O,
  output logic                           ALE_O,
  output logic                           RD_N_O,
  output logic                           WR_N_O,
  output logic [NUM_WIN:0]               CS_N_O,
  input  wire logic                      READY_I,
  input  wire logic                      HOLD_N_I,
  output logic                           BUS_REQUEST_OUT_N_O,
  input  wire logic                      BUS_GRANT_ACK_N_I,
  output logic                           BUS_GRANT_ACK_N_O,
  output logic                           BUS_GRANT_ACK_OE_O,
  output logic                           HOLD_STATE_O
);

  typedef struct packed {
    ebc_state_t        st;
    logic [1:0]        rdy_s;
    logic [1:0]        hold_s;
    logic [1:0]        ack_s;
    logic              arb_on;
    logic              slave;
    logic [3:0]        cnt;
    bus_cfg_t          cfg;
    logic [NUM_WIN:0]  sel;
    logic [NUM_WIN:0]  cs_n;
    logic [23:0]       addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              ale;
    logic              rd_n;
    logic              wr_n;
    logic              data_oe;
    logic [15:0]       dout;
    logic [15:0]       aout;
    logic [7:0]        seg;
    logic              done;
    logic [15:0]       rdata;
    logic              bus_request_out_n;
  } ebc_reg_t;

  ebc_reg_t r;
  ebc_reg_t next_r;

  // window decode: priority order 4 > 3 > 2 > 1, else default
  logic [NUM_WIN-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_hit
      assign hit[g] = WIN_CFG_I[g].enable &&
                      ((CPU_REQ_I.addr[23:12] & WIN_SEL_I[g].mask) ==
                       (WIN_SEL_I[g].base & WIN_SEL_I[g].mask));
    end
  endgenerate

  bus_cfg_t         pick_cfg;
  logic [NUM_WIN:0] pick_sel;
  logic [7:0]       seg_mask;
  logic             rdy_act;
  logic             is_mux;
  logic             is_8bit;

  always_comb begin
    pick_cfg = DEFAULT_CFG_I;
    pick_sel = (NUM_WIN+1)'(1);
    if (hit[3]) begin
      pick_cfg = WIN_CFG_I[3];
      pick_sel = (NUM_WIN+1)'(16);
    end else if (hit[2]) begin
      pick_cfg = WIN_CFG_I[2];
      pick_sel = (NUM_WIN+1)'(8);
    end else if (hit[1]) begin
      pick_cfg = WIN_CFG_I[1];
      pick_sel = (NUM_WIN+1)'(4);
    end else if (hit[0]) begin
      pick_cfg = WIN_CFG_I[0];
      pick_sel = (NUM_WIN+1)'(2);
    end
    case (ADDR_SPACE_I)
      SPACE_64K:  seg_mask = SEG_MASK_64K;
      SPACE_256K: seg_mask = SEG_MASK_256K;
      SPACE_1M:   seg_mask = SEG_MASK_1M;
      default:    seg_mask = SEG_MASK_16M;
    endcase
  end

  assign rdy_act = (r.rdy_s[1] == r.cfg.rdy_pol);
  assign is_mux  = (r.cfg.mode == MODE_MUX16) || (r.cfg.mode == MODE_MUX8);
  assign is_8bit = (r.cfg.mode == MODE_MUX8) || (r.cfg.mode == MODE_DEMUX8);

  always_comb begin
    next_r        = r;
    next_r.rdy_s  = {r.rdy_s[0], READY_I};
    next_r.hold_s = {r.hold_s[0], HOLD_N_I};
    next_r.ack_s  = {r.ack_s[0], BUS_GRANT_ACK_N_I};
    next_r.done   = 1'b0;
    if (ARB_ENABLE_I) begin
      next_r.arb_on = 1'b1;
    end
    next_r.slave  = ACK_DIR_I;
    case (r.st)
      S_IDLE: begin
        next_r.bus_request_out_n = 1'b1;
        if (r.arb_on && !r.slave && !r.hold_s[1]) begin
          next_r.st = S_HOLD;
        end else if (r.arb_on && r.slave && r.ack_s[1]) begin
          // slave without grant: request the bus
          next_r.bus_request_out_n = !CPU_REQ_I.req;
        end else if (CPU_REQ_I.req && !SINGLE_CHIP_I) begin
          next_r.cfg   = pick_cfg;
          next_r.sel   = pick_sel;
          next_r.addr  = CPU_REQ_I.addr;
          next_r.wdata = CPU_REQ_I.wdata;
          next_r.wr    = CPU_REQ_I.wr;
          next_r.seg   = CPU_REQ_I.addr[23:16] & seg_mask;
          next_r.aout  = CPU_REQ_I.addr[15:0];
          next_r.ale   = 1'b1;
          next_r.cnt   = CYC_RESET;
          if (pick_cfg.mode == MODE_MUX16 || pick_cfg.mode == MODE_MUX8) begin
            next_r.dout    = CPU_REQ_I.addr[15:0];
            next_r.data_oe = 1'b1;
          end
          // registered at the strobe rise; cs_neg adds the half-clock delay
          next_r.cs_n  = ~pick_sel;
          next_r.st = S_ALE;
        end
      end
      S_ALE: begin
        if (r.cfg.ale_long && r.cnt == CYC_RESET) begin
          next_r.cnt = 4'h1;
        end else begin
          next_r.ale = 1'b0;
          next_r.cnt = CYC_RESET;
          next_r.st  = r.cfg.rw_delay ? S_ADDR : S_WAIT;
          if (!r.cfg.rw_delay) begin
            next_r.rd_n = r.wr;
            next_r.wr_n = !r.wr;
          end
          next_r.data_oe = r.wr;
          next_r.dout    = is_8bit ? {8'h00, r.wdata[7:0]} : r.wdata;
        end
      end
      S_ADDR: begin
        next_r.rd_n = r.wr;
        next_r.wr_n = !r.wr;
        next_r.st   = S_WAIT;
      end
      S_WAIT: begin
        if (r.cnt != r.cfg.wait_cyc) begin
          next_r.cnt = r.cnt + 4'h1;
        end else if (!r.cfg.rdy_en || rdy_act) begin
          next_r.st = S_STRB;
        end
      end
      S_STRB: begin
        next_r.rd_n    = 1'b1;
        next_r.wr_n    = 1'b1;
        next_r.data_oe = 1'b0;
        next_r.cs_n    = '1;
        next_r.done    = 1'b1;
        next_r.rdata   = is_8bit ? {8'h00, DATA_PORT_I[7:0]} : DATA_PORT_I;
        next_r.st      = (r.cfg.tristate && !r.wr) ? S_TRI : S_IDLE;
      end
      S_TRI: begin
        next_r.st = S_IDLE;
      end
      S_HOLD: begin
        if (r.hold_s[1]) begin
          next_r.st = S_IDLE;
        end
      end
      default: begin
        next_r.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      r         <= '0;
      r.st      <= S_IDLE;
      r.rdy_s   <= 2'h0;
      r.hold_s  <= 2'h3;
      r.ack_s   <= 2'h3;
      r.cs_n    <= '1;
      r.rd_n    <= 1'b1;
      r.wr_n    <= 1'b1;
      r.bus_request_out_n  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // half-cycle delayed chip select for the default timing
  logic [NUM_WIN:0] cs_neg;
  always_ff @(negedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      cs_neg <= '1;
    end else begin
      cs_neg <= r.cs_n;
    end
  end

  assign CS_N_O              = CS_TIMING_I ? r.cs_n : cs_neg;
  assign CPU_DONE_O          = r.done;
  assign CPU_RDATA_O         = r.rdata;
  assign ADDRESS_PORT_O      = is_mux ? 16'h0000 : r.aout;
  assign DATA_PORT_O         = r.dout;
  assign DATA_PORT_OE_O      = !r.data_oe ? 16'h0000 : (is_8bit && r.st != S_ALE) ? 16'h00ff : 16'hffff;
  assign SEGMENT_O           = r.seg;
  assign ALE_O               = r.ale;
  assign RD_N_O              = r.rd_n;
  assign WR_N_O              = r.wr_n;
  assign BUS_REQUEST_OUT_N_O = r.bus_request_out_n;
  assign HOLD_STATE_O        = (r.st == S_HOLD);
  assign BUS_GRANT_ACK_N_O   = !(r.st == S_HOLD);
  assign BUS_GRANT_ACK_OE_O  = r.arb_on && !r.slave;

  a_hold_grant_out: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_HOLD) |-> (BUS_GRANT_ACK_OE_O || r.slave))
    else $error("grant not driven in master hold");
  a_ready_waits: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_WAIT && r.cnt == r.cfg.wait_cyc && r.cfg.rdy_en && !rdy_act) |=> (r.st == S_WAIT))
    else $error("cycle ended without ready");
  a_mux_addr_first: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_ALE && is_mux) |-> (DATA_PORT_O == r.addr[15:0]))
    else $error("mux address not on data port");
  a_seg_restrict: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (ADDR_SPACE_I == SPACE_64K && $stable(ADDR_SPACE_I)) |=> (r.st != S_ALE || SEGMENT_O == 8'h00))
    else $error("segment lines driven at 64K");
  a_window_prio: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_IDLE && next_r.st == S_ALE && hit[3]) |=> r.sel[4])
    else $error("window four lost priority");
  a_default_sel: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_IDLE && next_r.st == S_ALE && hit == '0) |=> r.sel[0])
    else $error("default region not selected");
  a_single_chip: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (SINGLE_CHIP_I && r.st == S_IDLE) |=> (r.st != S_ALE))
    else $error("bus cycle in single chip mode");
  a_ale_length: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ($rose(ALE_O) && r.cfg.ale_long) |-> ALE_O [*2])
    else $error("long strobe too short");
  a_cs_early: assert property (@(posedge MCLK_I) disable iff (RST_I)
    ($rose(ALE_O) && CS_TIMING_I && $stable(CS_TIMING_I)) |-> (CS_N_O == ~r.sel))
    else $error("chip select not at strobe rise");
  a_slave_request: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_IDLE && r.arb_on && r.slave && r.ack_s[1] && CPU_REQ_I.req) |=>
      (!BUS_REQUEST_OUT_N_O && r.st == S_IDLE))
    else $error("slave started a cycle without grant");
  a_byte_lane: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_WAIT && r.wr && is_8bit) |->
      (DATA_PORT_OE_O == 16'h00ff && DATA_PORT_O[15:8] == 8'h00))
    else $error("8-bit write drives the high byte");
  a_demux_addr: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_WAIT && !is_mux) |-> (ADDRESS_PORT_O == r.addr[15:0]))
    else $error("address port lost the address");
  a_ready_level: assert property (@(posedge MCLK_I) disable iff (RST_I)
    (r.st == S_WAIT && r.cnt == r.cfg.wait_cyc && r.cfg.rdy_en && r.rdy_s[1] == r.cfg.rdy_pol) |=>
      (r.st == S_STRB))
    else $error("ready at its active level ignored");

endmodule
`default_nettype wire

// *** verification/ext_mem_model.sv ***
/*
  external memory on the far side of the bus controller: 256 words, ready with
  a chosen active level and delay. assumes strobes registered on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
  import ebc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ale_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [15:0] dq_oe_i,
  input  wire logic        rdy_pol_i,
  input  wire logic [3:0]  rdy_dly_i,
  output logic      [15:0] dq_o,
  output logic             ready_o
);
  logic [15:0] mem [256];
  logic [7:0]  a;
  logic [15:0] idle;
  logic [3:0]  n;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle <= 16'h5a5a;
      n    <= 4'h0;
    end else begin
      idle <= ~idle;
      // address taken while the strobe is high: shared port if driven, else address port
      if (ale_i) a <= (|dq_oe_i) ? dq_i[7:0] : addr_i[7:0];
      if (!wr_n_i) mem[a] <= dq_i;
      n <= (rd_n_i && wr_n_i) ? 4'h0 : n + {3'h0, n != 4'hf};
    end
  end
  // released lines show a pattern that changes every cycle
  assign dq_o    = rd_n_i ? idle : mem[a];
  assign ready_o = ((!rd_n_i || !wr_n_i) && n >= rdy_dly_i) ? rdy_pol_i : ~rdy_pol_i;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
/*
  testbench of the external bus controller: window table, then timing, space,
  chip select timing, single chip, hold and reset tests. assumes ext_mem_model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ebc_pkg::*;
  typedef struct packed {
    logic [23:0] a;
    logic [15:0] d;
    logic [4:0]  cs;
    logic        b8;
    logic        pol;
    logic [3:0]  dly;
  } row_t;
  logic                   MCLK_I, RST_I, SINGLE_CHIP_I, CS_TIMING_I, ARB_ENABLE_I, ACK_DIR_I, HOLD_N_I;
  logic                   grant_in_n, rdy_pol, CPU_DONE_O, ALE_O, RD_N_O, WR_N_O, READY_I, BUS_REQUEST_OUT_N_O;
  logic                   BUS_GRANT_ACK_N_O, BUS_GRANT_ACK_OE_O, HOLD_STATE_O;
  logic [1:0]             ADDR_SPACE_I;
  logic [3:0]             rdy_dly;
  logic [4:0]             CS_N_O, cs;
  logic [7:0]             SEGMENT_O, sg;
  logic [15:0]            CPU_RDATA_O, ADDRESS_PORT_O, DATA_PORT_O, DATA_PORT_OE_O, mem_dq, pin, q;
  cpu_req_t               req;
  bus_cfg_t               dcfg;
  bus_cfg_t [NUM_WIN-1:0] wcfg;
  win_sel_t [NUM_WIN-1:0] wsel;
  int                     err_total, n_compared, cyc, n;
  row_t                   rows [5];
  logic [7:0]             masks [4] = '{SEG_MASK_64K, SEG_MASK_256K, SEG_MASK_1M, SEG_MASK_16M};
  assign pin = (DATA_PORT_OE_O & DATA_PORT_O) | (~DATA_PORT_OE_O & mem_dq);
  ext_bus_ctrl u_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CPU_REQ_I(req), .CPU_DONE_O(CPU_DONE_O),
    .CPU_RDATA_O(CPU_RDATA_O), .DEFAULT_CFG_I(dcfg), .WIN_CFG_I(wcfg), .WIN_SEL_I(wsel),
    .SINGLE_CHIP_I(SINGLE_CHIP_I), .ADDR_SPACE_I(ADDR_SPACE_I), .CS_TIMING_I(CS_TIMING_I),
    .ARB_ENABLE_I(ARB_ENABLE_I), .ACK_DIR_I(ACK_DIR_I), .ADDRESS_PORT_O(ADDRESS_PORT_O),
    .DATA_PORT_O(DATA_PORT_O), .DATA_PORT_OE_O(DATA_PORT_OE_O), .DATA_PORT_I(pin), .SEGMENT_O(SEGMENT_O),
    .ALE_O(ALE_O), .RD_N_O(RD_N_O), .WR_N_O(WR_N_O), .CS_N_O(CS_N_O), .READY_I(READY_I), .HOLD_N_I(HOLD_N_I),
    .BUS_REQUEST_OUT_N_O(BUS_REQUEST_OUT_N_O), .BUS_GRANT_ACK_N_I(grant_in_n),
    .BUS_GRANT_ACK_N_O(BUS_GRANT_ACK_N_O), .BUS_GRANT_ACK_OE_O(BUS_GRANT_ACK_OE_O), .HOLD_STATE_O(HOLD_STATE_O));
  ext_mem_model u_mem (.clk_i(MCLK_I), .rst_i(RST_I), .ale_i(ALE_O), .rd_n_i(RD_N_O), .wr_n_i(WR_N_O),
    .addr_i(ADDRESS_PORT_O), .dq_i(DATA_PORT_O), .dq_oe_i(DATA_PORT_OE_O), .rdy_pol_i(rdy_pol),
    .rdy_dly_i(rdy_dly), .dq_o(mem_dq), .ready_o(READY_I));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one cpu access; leaves cycle count, chip selects and segment seen during the strobe
  task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d);
    n = 0;
    cs = 5'h1f;
    sg = 8'h00;
    @(negedge MCLK_I);
    req = '{1'b1, w, a, d};
    do begin
      @(posedge MCLK_I);
      #1 n++;
      if (!RD_N_O || !WR_N_O) begin
        cs = CS_N_O;
        sg = SEGMENT_O;
      end
    end while (CPU_DONE_O !== 1'b1 && n < 200);
    chk(CPU_DONE_O, 1'b1);
    q = CPU_RDATA_O;
    @(negedge MCLK_I);
    req.req = 1'b0;
  endtask
  initial begin
    MCLK_I = 1'b0;
    forever #50 MCLK_I = ~MCLK_I;
  end
  always @(posedge MCLK_I) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    RST_I = 1'b1;
    req = '0;
    SINGLE_CHIP_I = 1'b0;
    CS_TIMING_I = 1'b0;
    ARB_ENABLE_I = 1'b0;
    ACK_DIR_I = 1'b0;
    HOLD_N_I = 1'b1;
    grant_in_n = 1'b1;
    ADDR_SPACE_I = SPACE_16M;
    rdy_pol = 1'b1;
    rdy_dly = 4'h0;
    dcfg = '{1'b1, MODE_DEMUX16, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    wcfg[0] = '{1'b1, MODE_DEMUX16, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    wcfg[1] = '{1'b1, MODE_MUX16, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    wcfg[2] = '{1'b1, MODE_MUX8, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    wcfg[3] = '{1'b1, MODE_DEMUX8, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wsel = '{'{12'h020, 12'hfff}, '{12'h020, 12'hff0}, '{12'h010, 12'hff8}, '{12'h010, 12'hff0}};
    rows[0] = '{24'h018010, 16'h1234, 5'h1d, 1'b0, 1'b1, 4'h0};
    rows[1] = '{24'h012020, 16'h5678, 5'h1b, 1'b0, 1'b1, 4'h0};
    rows[2] = '{24'h021030, 16'h009a, 5'h17, 1'b1, 1'b1, 4'h0};
    rows[3] = '{24'h020040, 16'h00bc, 5'h0f, 1'b1, 1'b0, 4'h4};
    rows[4] = '{24'h5a3050, 16'hdef0, 5'h1e, 1'b0, 1'b1, 4'h0};
    repeat (20) @(negedge MCLK_I);
    RST_I = 1'b0;
    for (int i = 0; i < 5; i++) begin
      rdy_pol = rows[i].pol;
      rdy_dly = rows[i].dly;
      acc(1'b1, rows[i].a, rows[i].d);
      chk(cs, rows[i].cs);
      acc(1'b0, rows[i].a, 16'h0);
      chk(rows[i].b8 ? q[7:0] : q, rows[i].b8 ? rows[i].d[7:0] : rows[i].d);
      chk(cs, rows[i].cs);
      chk(sg, rows[i].a[23:16]);
      if (rows[i].dly != 4'h0) chk(n > 8, 1'b1);
    end
    dcfg = '{1'b1, MODE_DEMUX16, 4'h3, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    acc(1'b1, 24'h5a3050, 16'h0f0f);
    chk(n, 9);
    for (int s = 0; s < 4; s++) begin
      ADDR_SPACE_I = s[1:0];
      acc(1'b0, 24'hc35050, 16'h0);
      chk(sg, 8'hc3 & masks[s]);
    end
    for (int t = 0; t < 2; t++) begin
      CS_TIMING_I = t[0];
      fork
        acc(1'b0, 24'h5a3050, 16'h0);
        begin
          @(posedge ALE_O);
          #1 chk(CS_N_O, t[0] ? 5'h1e : 5'h1f);
          #50 chk(CS_N_O, 5'h1e);
        end
      join
    end
    SINGLE_CHIP_I = 1'b1;
    @(negedge MCLK_I);
    req = '{1'b1, 1'b0, 24'h5a3050, 16'h0};
    n = 0;
    repeat (20) begin
      @(posedge MCLK_I);
      #1 n += int'(CPU_DONE_O === 1'b1 || ALE_O !== 1'b0);
    end
    chk(n, 0);
    @(negedge MCLK_I) req.req = 1'b0;
    SINGLE_CHIP_I = 1'b0;
    ARB_ENABLE_I = 1'b1;
    HOLD_N_I = 1'b0;
    repeat (8) @(negedge MCLK_I);
    chk({HOLD_STATE_O, BUS_GRANT_ACK_N_O, BUS_GRANT_ACK_OE_O}, 3'b101);
    HOLD_N_I = 1'b1;
    repeat (8) @(negedge MCLK_I);
    chk({HOLD_STATE_O, BUS_GRANT_ACK_N_O, BUS_GRANT_ACK_OE_O}, 3'b011);
    ACK_DIR_I = 1'b1;
    repeat (4) @(negedge MCLK_I);
    chk(BUS_GRANT_ACK_OE_O, 1'b0);
    req = '{1'b1, 1'b0, 24'h018010, 16'h0};
    repeat (4) @(negedge MCLK_I);
    chk({BUS_REQUEST_OUT_N_O, ALE_O}, 2'b00);
    req.req = 1'b0;
    grant_in_n = 1'b0;
    acc(1'b0, 24'h018010, 16'h0);
    chk(q, 16'h1234);
    RST_I = 1'b1;
    ARB_ENABLE_I = 1'b0;
    ACK_DIR_I = 1'b0;
    #10 chk({CS_N_O, ALE_O, RD_N_O, WR_N_O, CPU_DONE_O, BUS_GRANT_ACK_OE_O, |DATA_PORT_OE_O}, {5'h1f, 6'b011000});
    repeat (20) @(negedge MCLK_I);
    RST_I = 1'b0;
    acc(1'b0, 24'h018010, 16'h0);
    chk(q, 16'h1234);
    summarize();
  end
endmodule
`default_nettype wire
